// ### hdl/ssp_pkg.sv
package ssp_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] BUF_OFS = 8'h08;
  localparam logic [7:0] BAUD_OFS = 8'h0C;
  localparam logic [7:0] IRQ_OFS = 8'h10;
  localparam logic [7:0] MASK_OFS = 8'h14;
  // control register fields
  localparam int CTRL_RATE_LSB = 0;
  localparam int CTRL_POL_BIT = 4;
  localparam int CTRL_EN_BIT = 5;
  localparam int CTRL_MODE_BIT = 6;
  // status register fields
  localparam int STAT_FULL_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_EDGE_BIT = 6;
  localparam int STAT_PHASE_BIT = 7;
  // interrupt status fields
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_COLL_BIT = 1;
  // reset values
  localparam logic [3:0] CTRL_RATE_RST = 4'h0;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [1:0] MASK_RST = 2'h0;
  // bit-rate selections
  localparam logic [3:0] RATE_DIV4 = 4'h0;
  localparam logic [3:0] RATE_DIV16 = 4'h1;
  localparam logic [3:0] RATE_DIV64 = 4'h2;
  localparam logic [3:0] RATE_TIMER = 4'h3;
  localparam logic [3:0] RATE_BAUD = 4'hA;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} ssp_state_t;
endpackage

// ### hdl/ssp_master.sv
`timescale 1ns/1ps
module ssp_master
  import ssp_pkg::*;
(
  input wire logic clk, // 25 MHz system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic timerTick, // auxiliary timer output pulse
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic serialClockLine, // serial clock out
  output logic serialOutLine, // serial data out
  output logic serialOutEn, // serial data output enable
  input wire logic serialInLine, // serial data in pin
  output logic irq // level interrupt
);
  import ssp_pkg::*;

  // ****************************************************
  // state
  // ****************************************************
  logic [3:0] rate_r;
  logic pol_r, en_r, mode_r, edge_r, phase_r, outDis_r;
  logic [7:0] baud_r, rxBuf_r, shift_r;
  logic full_r;
  logic [1:0] irqStat_r, mask_r;
  ssp_state_t state_r;
  logic [2:0] bitCnt_r;
  logic [15:0] divCnt_r;
  logic smp_r;
  logic sin1_r, sin2_r, tmr1_r, tmr2_r, tmrPrev_r, tmrHalf_r;
  logic [7:0] awAddr_r, arAddr_r;
  logic awHave_r, wHave_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;

  // ****************************************************
  // input synchronisers
  // ****************************************************
  always_ff @(posedge clk)
  begin
    sin1_r <= serialInLine;
    sin2_r <= sin1_r;
    tmr1_r <= timerTick;
    tmr2_r <= tmr1_r;
    if (sys_rst)
    begin
      tmrPrev_r <= 1'b0;
      tmrHalf_r <= 1'b0;
    end
    else
    begin
      tmrPrev_r <= tmr2_r;
      if (tmr2_r && !tmrPrev_r)
        tmrHalf_r <= !tmrHalf_r;
    end
  end

  // ****************************************************
  // bit-rate: half-period length in system clocks
  // ****************************************************
  // returns the number of clocks per serial clock half period
  function automatic logic [15:0] halfPeriod(input logic [3:0] sel,
                                             input logic [7:0] reload);
  begin
    unique case (sel)
      RATE_DIV16: halfPeriod = 16'd8;
      RATE_DIV64: halfPeriod = 16'd32;
      RATE_BAUD: halfPeriod = 16'({reload, 1'b0}) + 16'd2;
      default: halfPeriod = 16'd2;
    endcase
  end
  endfunction

  logic timerMode;
  logic halfTick;
  logic [15:0] halfLen;
  assign timerMode = (rate_r == RATE_TIMER);
  assign halfLen = halfPeriod(rate_r, baud_r);
  // timer rate: each timer pulse is half a serial clock period
  assign halfTick = timerMode ? (tmr2_r && !tmrPrev_r)
                              : (divCnt_r == halfLen - 16'd1);

  // ****************************************************
  // register bus: write channel
  // ****************************************************
  logic wrGo;
  logic bufWrite;
  assign wrGo = awHave_r && wHave_r && !s_axi_bvalid;
  assign bufWrite = wrGo && awAddr_r == BUF_OFS && wStrb_r[0];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
    end
    else
    begin
      s_axi_awready <= !awHave_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !wHave_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wrGo)
      begin
        awHave_r <= 1'b0;
        wHave_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_r[7:2] <= MASK_OFS[7:2] &&
                        awAddr_r[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************
  // configuration registers
  // ****************************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rate_r <= CTRL_RATE_RST;
      pol_r <= 1'b0;
      en_r <= 1'b0;
      mode_r <= 1'b0;
      edge_r <= 1'b0;
      phase_r <= 1'b0;
      outDis_r <= 1'b0;
      baud_r <= BAUD_RST;
      mask_r <= MASK_RST;
    end
    else if (wrGo && wStrb_r[0])
    begin
      unique case (awAddr_r)
        CTRL_OFS:
        begin
          rate_r <= wData_r[CTRL_RATE_LSB +: 4];
          pol_r <= wData_r[CTRL_POL_BIT];
          en_r <= wData_r[CTRL_EN_BIT];
          // two-wire mode not built; setting it just holds the port off
          mode_r <= wData_r[CTRL_MODE_BIT];
          outDis_r <= wData_r[7];
        end
        STAT_OFS:
        begin
          edge_r <= wData_r[STAT_EDGE_BIT];
          phase_r <= wData_r[STAT_PHASE_BIT];
        end
        BAUD_OFS: baud_r <= wData_r[7:0];
        MASK_OFS: mask_r <= wData_r[1:0];
        default: ;
      endcase
    end
  end

  // ****************************************************
  // shift engine
  // ****************************************************
  logic spiOn;
  logic startXfer;
  logic lastBit;
  logic sampleLate;
  assign spiOn = en_r && !mode_r;
  // edge select zero moves data on the leading edge, so mid-bit is the
  // trailing edge; its last bit has no later edge, so both phases use it
  // the two-flop input delay needs half periods of three clocks or more
  assign sampleLate = phase_r || !edge_r;
  // a write while busy is dropped and flagged as a collision
  assign startXfer = bufWrite && spiOn && state_r == ST_IDLE;
  assign lastBit = (bitCnt_r == 3'd7);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r <= ST_IDLE;
      divCnt_r <= 16'h0000;
      bitCnt_r <= 3'd0;
      shift_r <= 8'h00;
      smp_r <= 1'b0;
      serialClockLine <= 1'b0;
      serialOutLine <= 1'b0;
      serialOutEn <= 1'b0;
    end
    else
    begin
      serialOutEn <= spiOn && !outDis_r;
      if (state_r == ST_IDLE || halfTick)
        divCnt_r <= 16'h0000;
      else
        divCnt_r <= divCnt_r + 16'd1;
      unique case (state_r)
        ST_IDLE:
        begin
          serialClockLine <= pol_r;
          if (startXfer)
          begin
            shift_r <= wData_r[7:0];
            bitCnt_r <= 3'd0;
            state_r <= ST_LEAD;
            // edge select one: first bit out before any edge
            if (edge_r)
              serialOutLine <= wData_r[7];
          end
        end
        ST_LEAD:
          if (halfTick)
          begin
            serialClockLine <= !pol_r;
            // edge select zero: data moves on the leading edge
            if (!edge_r)
              serialOutLine <= shift_r[7];
            // edge select one: mid-bit falls on the leading edge
            if (edge_r && !phase_r)
              smp_r <= sin2_r;
            state_r <= ST_TRAIL;
          end
        ST_TRAIL:
          if (halfTick)
          begin
            serialClockLine <= pol_r;
            shift_r <= {shift_r[6:0],
                        sampleLate ? sin2_r : smp_r};
            if (edge_r && !lastBit)
              serialOutLine <= shift_r[6];
            bitCnt_r <= bitCnt_r + 3'd1;
            state_r <= lastBit ? ST_IDLE : ST_LEAD;
          end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  logic doneEv;
  logic collEv;
  assign doneEv = state_r == ST_TRAIL && halfTick && lastBit;
  assign collEv = bufWrite && state_r != ST_IDLE;

  // ****************************************************
  // receive buffer, flags and interrupt
  // ****************************************************
  logic bufRead;
  logic irqClrWr;
  assign bufRead = s_axi_arvalid && s_axi_arready && s_axi_araddr == BUF_OFS;
  assign irqClrWr = wrGo && awAddr_r == IRQ_OFS && wStrb_r[0];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rxBuf_r <= 8'h00;
      full_r <= 1'b0;
      irqStat_r <= 2'b00;
      irq <= 1'b0;
    end
    else
    begin
      if (doneEv)
      begin
        rxBuf_r <= {shift_r[6:0], sampleLate ? sin2_r : smp_r};
        full_r <= 1'b1;
      end
      else if (bufRead)
        full_r <= 1'b0;
      // set beats a simultaneous write-one clear
      irqStat_r[IRQ_DONE_BIT] <= doneEv ||
        (irqStat_r[IRQ_DONE_BIT] &&
         !(irqClrWr && wData_r[IRQ_DONE_BIT]));
      irqStat_r[IRQ_COLL_BIT] <= collEv ||
        (irqStat_r[IRQ_COLL_BIT] && !(irqClrWr && wData_r[IRQ_COLL_BIT]));
      irq <= |(irqStat_r & mask_r);
    end
  end

  // ****************************************************
  // register bus: read channel
  // ****************************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        unique case (s_axi_araddr)
          CTRL_OFS: s_axi_rdata[7:0] <= {outDis_r, mode_r, en_r, pol_r,
                                         rate_r};
          STAT_OFS: s_axi_rdata[7:0] <= {phase_r, edge_r, 4'h0,
                                         state_r != ST_IDLE, full_r};
          BUF_OFS: s_axi_rdata[7:0] <= rxBuf_r;
          BAUD_OFS: s_axi_rdata[7:0] <= baud_r;
          IRQ_OFS: s_axi_rdata[1:0] <= irqStat_r;
          MASK_OFS: s_axi_rdata[1:0] <= mask_r;
          default: s_axi_rresp <= RESP_SLVERR;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ### dv/ssp_chk.sv
`timescale 1ns/1ps
module ssp_chk
  import ssp_pkg::*;
(
  input wire logic clk, // clock
  input wire logic sys_rst, // reset
  input wire logic s_axi_bvalid, // write answer
  input wire logic s_axi_bready, // write taken
  input wire logic s_axi_rvalid, // read answer
  input wire logic s_axi_rready, // read taken
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read resp
  input wire logic serialClockLine, // serial clock
  input wire logic serialOutEn, // out enable
  input wire logic irq // interrupt
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped");
  a_rvalid_held: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid moved");
  a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("extra write answer");
  a_rvalid_once: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid) else $error("extra read answer");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp ==
    RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000) else $error("err data");
  a_upper_zero: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:8] == 24'h00_0000) else $error("upper bits set");
  a_sclk_half_min: assert property ($changed(serialClockLine)
    |=> $stable(serialClockLine)) else $error("half period short");
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !irq
    && !serialClockLine && !serialOutEn && !s_axi_bvalid)
    else $error("outputs busy in reset");
  cover property ($rose(irq));
  cover property ($changed(serialClockLine));
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
bind ssp_master ssp_chk chk_i (
  .clk(clk),
  .sys_rst(sys_rst),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .serialClockLine(serialClockLine),
  .serialOutEn(serialOutEn),
  .irq(irq)
);

// ### dv/ssp_slave_model.sv
`timescale 1ns/1ps
module ssp_slave_model (
  input wire logic serialClockLine, // clock from master
  input wire logic serialOutLine, // data from master
  input wire logic pol, // idle clock level
  input wire logic edgeSel, // edge select
  output logic serialInLine // data to master
);
  logic [7:0] txByte = 8'h00;
  logic [7:0] rxByte = 8'h00;
  logic first = 1'b1;
  assign serialInLine = txByte[7];
  task automatic preload(input logic [7:0] b);
    txByte = b;
    rxByte = 8'h00;
    first = 1'b1;
  endtask
  // leading edge leaves the idle level
  always @(serialClockLine)
  begin
    if (serialClockLine != pol)
    begin
      if (edgeSel)
        rxByte <= {rxByte[6:0], serialOutLine};
      else if (first)
        first <= 1'b0;
      else
        txByte <= {txByte[6:0], 1'b0};
    end
    else if (edgeSel)
      txByte <= {txByte[6:0], 1'b0};
    else
      rxByte <= {rxByte[6:0], serialOutLine};
  end
endmodule

// ### dv/ssp_tb.sv
`timescale 1ns/1ps
module testbench;
  import ssp_pkg::*;
  logic clk = 0, sys_rst = 1, timerTick = 0, pol = 0, edgeSel = 0;
  logic awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
  logic [7:0] awAddr = 0, arAddr = 0;
  logic [31:0] wData = 0, rData;
  logic [1:0] bResp, rResp;
  logic awReady, wReady, bValid, arReady, rValid, sclk, sdo, sdoEn;
  logic sdi, irq;
  wire sdoWire = sdoEn ? sdo : 1'b1; // pulled up when released
  int miscompares = 0, numChecks = 0, tickCnt = 0;
  ssp_master uut (.clk(clk), .sys_rst(sys_rst), .timerTick(timerTick),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .serialClockLine(sclk), .serialOutLine(sdo),
    .serialOutEn(sdoEn), .serialInLine(sdi), .irq(irq));
  ssp_slave_model slv (.serialClockLine(sclk), .serialOutLine(sdoWire),
    .pol(pol), .edgeSel(edgeSel), .serialInLine(sdi));
  initial
  begin
    forever #20 clk = ~clk;
  end
  // timer rises every six clocks
  always @(posedge clk)
  begin
    tickCnt <= (tickCnt == 2) ? 0 : tickCnt + 1;
    if (tickCnt == 2)
      timerTick <= ~timerTick;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic hang();
    miscompares++;
    final_report();
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    numChecks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    int n;
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (n = 0; n < 99 && !bValid; n++)
    begin
      @(posedge clk);
      if (awReady)
        awValid <= 1'b0;
      if (wReady)
        wValid <= 1'b0;
    end
    r = bResp;
    bReady <= 1'b0;
    @(posedge clk);
    if (n == 99)
      hang();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (n = 0; n < 99 && !rValid; n++)
    begin
      @(posedge clk);
      if (arReady)
        arValid <= 1'b0;
    end
    d = rData;
    r = rResp;
    rReady <= 1'b0;
    @(posedge clk);
    if (n == 99)
      hang();
  endtask
  task automatic waitIrq(input logic lvl, input int lim);
    int n;
    for (n = 0; n < lim && irq !== lvl; n++)
      @(posedge clk);
    if (n == lim)
      hang();
  endtask
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    chk("irq", 0, irq);
    rd(CTRL_OFS, d, r);
    chk("control", 0, d);
    rd(MASK_OFS, d, r);
    chk("mask", MASK_RST, d);
    rd(8'h20, d, r);
    chk("unmapped resp", RESP_SLVERR, r);
    chk("unmapped data", 0, d);
    wr(8'h0A, 32'h0000_0001, r);
    chk("misaligned resp", RESP_SLVERR, r);
    wr(MASK_OFS, 32'h0000_0001, r);
  endtask
  // collision flag is masked so only the done event may raise irq
  task automatic xfer(input logic [3:0] rate, input logic p, e, ph, dis,
    input logic [7:0] rl, tx, sb, input int hp);
    int n;
    logic s0;
    logic [31:0] d;
    logic [1:0] r;
    pol <= p;
    edgeSel <= e;
    wr(BAUD_OFS, {24'h00_0000, rl}, r);
    wr(CTRL_OFS, {24'h00_0000, dis, 2'b01, p, rate}, r);
    wr(STAT_OFS, {24'h00_0000, ph, e, 6'h00}, r);
    slv.preload(sb);
    chk("idle clock", p, sclk);
    s0 = sclk;
    wr(BUF_OFS, {24'h00_0000, tx}, r);
    for (n = 0; n < 99 && sclk === s0; n++) @(posedge clk);
    if (n == 99)
      hang();
    s0 = sclk;
    for (n = 0; n < 99 && sclk === s0; n++) @(posedge clk);
    chk("half period", hp, n);
    chk("drive enable", !dis, sdoEn);
    wr(BUF_OFS, 32'h0000_00FF, r);
    waitIrq(1'b1, 1200);
    chk("slave got", dis ? 8'hFF : tx, slv.rxByte);
    rd(STAT_OFS, d, r);
    chk("status", {ph, e, 6'h01}, d);
    if (hp > 2)
    begin
      rd(BUF_OFS, d, r);
      chk("rx byte", sb, d);
    end
    rd(IRQ_OFS, d, r);
    chk("flags", 32'h0000_0003, d);
    wr(IRQ_OFS, 32'h0000_0003, r);
    waitIrq(1'b0, 20);
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    xfer(RATE_DIV4, 0, 0, 0, 0, 8'h00, 8'hA5, 8'h3C, 2);
    xfer(RATE_DIV16, 1, 1, 0, 0, 8'h00, 8'h81, 8'h7E, 8);
    xfer(RATE_DIV64, 0, 1, 0, 0, 8'h00, 8'h5A, 8'hC3, 32);
    xfer(RATE_TIMER, 1, 0, 0, 0, 8'h00, 8'h01, 8'h80, 6);
    xfer(RATE_BAUD, 0, 0, 0, 1, 8'h02, 8'hF0, 8'h0F, 6);
    xfer(RATE_DIV16, 0, 1, 1, 0, 8'h00, 8'h69, 8'h96, 8);
    final_report();
  end
endmodule
